//--- design/uetc_pkg.sv
// constants, command codes and sequencer states of the endpoint transaction controller
// Function
// - control IN data: set direction, fill FIFO, set ready, later clear done flag
// - OUT data stage keeps direction 0; read FIFO then clear bank 0 flag
// - direction bit goes back to 0 for any status stage
// - control write/no-data status is IN zero-length; control read status is OUT zero-length
// - iso IN sent sets done flag without handshake; clear it before refilling
// - never load more bytes than the endpoint FIFO holds
// - end of bus reset sets flag and resets registers; clear flag to re-arm
// - stall only for control/bulk/interrupt: clear flags, then set stall request
// - clear stall request and stall flag after each STALL; SETUP clears request
// - after clear-halt, reset the endpoint through the FIFO reset register
// - start-of-frame sets frame flag; clear it for the next detection
package uetc_pkg;

  // apb register offsets of the controller
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STAT = 8'h04;
  localparam logic [7:0] APB_COUNT = 8'h08;
  localparam logic [7:0] APB_FRAME = 8'h0C;
  localparam logic [7:0] APB_EVENTS = 8'h10;
  localparam logic [7:0] APB_PTR = 8'h14;
  localparam logic [7:0] APB_DATA = 8'h18;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_EP_LSB = 4;
  localparam int CMD_OPT_BIT = 8;
  localparam int CMD_LEN_LSB = 16;
  localparam int CMD_LEN_W = 10;

  // command codes
  localparam logic [3:0] OP_TX = 4'h1;
  localparam logic [3:0] OP_RX = 4'h2;
  localparam logic [3:0] OP_TXDONE = 4'h3;
  localparam logic [3:0] OP_STALL = 4'h4;
  localparam logic [3:0] OP_UNSTALL = 4'h5;
  localparam logic [3:0] OP_STATUS = 4'h6;
  localparam logic [3:0] OP_EPRST = 4'h7;
  localparam logic [3:0] OP_EVENTS = 4'h8;

  // device register offsets on its own register port
  localparam logic [7:0] D_EP_SELECT = 8'h00;
  localparam logic [7:0] D_EP_STATUS = 8'h01;
  localparam logic [7:0] D_FIFO = 8'h02;
  localparam logic [7:0] D_COUNT_LO = 8'h03;
  localparam logic [7:0] D_COUNT_HI = 8'h04;
  localparam logic [7:0] D_EVENTS = 8'h05;
  localparam logic [7:0] D_FRAME_LO = 8'h06;
  localparam logic [7:0] D_FRAME_HI = 8'h07;
  localparam logic [7:0] D_EP_RESET = 8'h08;

  // endpoint_status_control bits
  localparam logic [7:0] M_TX_DONE = 8'h01;
  localparam logic [7:0] M_RX_BANK0 = 8'h02;
  localparam logic [7:0] M_SETUP = 8'h04;
  localparam logic [7:0] M_STALL_CRC = 8'h08;
  localparam logic [7:0] M_TX_READY = 8'h10;
  localparam logic [7:0] M_STALL_REQ = 8'h20;
  localparam logic [7:0] M_RX_BANK1 = 8'h40;
  localparam logic [7:0] M_DIR = 8'h80;

  // bus_event_flags bits and frame_number_high layout
  localparam logic [7:0] M_EV_FRAME = 8'h08;
  localparam logic [7:0] M_EV_BUS_RESET = 8'h10;
  localparam int FNH_GOOD_BIT = 3;
  localparam int FNH_BAD_BIT = 4;

  // status register and frame register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RX_NONE_BIT = 1;
  localparam int ST_CRC_BAD_BIT = 2;
  localparam int ST_IRQ_BIT = 3;
  localparam int ST_EPSTAT_LSB = 8;
  localparam int FR_GOOD_BIT = 16;
  localparam int FR_BAD_BIT = 17;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [3:0] {
    S_IDLE, S_SEL, S_STAT_RD, S_PREP_WR, S_DATA_WR, S_FINAL_WR, S_CNT_LO, S_CNT_HI,
    S_DATA_RD, S_FLAG_CLR, S_RST_SET, S_RST_CLR, S_EVT_RD, S_FN_LO, S_FN_HI, S_EVT_CLR
  } uetc_state_t;

endpackage : uetc_pkg

//--- design/uetc_buf_mem.sv
// packet buffer memory with registered read data
module uetc_buf_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // array has no reset so it can map onto ram
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : uetc_buf_mem

//--- design/uetc_ctrl.sv
// controller that services the usb endpoint logic through its register port, steered over apb
//
// Added by the designer: the APB slave port and the placing of the registers.
module uetc_ctrl #(
  parameter int unsigned BUF_DEPTH = 64,
  parameter int unsigned FIFO_BYTES = 64
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device register port
  output logic dev_req,
  output logic dev_we,
  output logic [7:0] dev_addr,
  output logic [7:0] dev_wdata,
  input wire logic [7:0] dev_rdata,
  input wire logic dev_ack,
  input wire logic dev_irq
);

  localparam int unsigned AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [15:0] TX_CAP = 16'((FIFO_BYTES < BUF_DEPTH) ? FIFO_BYTES : BUF_DEPTH);
  localparam logic [15:0] RX_CAP = 16'(BUF_DEPTH);

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] cap);
    return (v > cap) ? cap : v;
  endfunction : clamp

  function automatic uetc_pkg::uetc_state_t first_state(input logic [3:0] op);
    uetc_pkg::uetc_state_t s;
    s = uetc_pkg::S_IDLE;
    if (op == uetc_pkg::OP_EVENTS) begin
      s = uetc_pkg::S_EVT_RD;
    end else if (op == uetc_pkg::OP_EPRST) begin
      s = uetc_pkg::S_RST_SET;
    end else if (op >= uetc_pkg::OP_TX && op <= uetc_pkg::OP_STATUS) begin
      s = uetc_pkg::S_SEL;
    end
    return s;
  endfunction : first_state

  uetc_pkg::uetc_state_t state_r;
  uetc_pkg::uetc_state_t state_nxt;
  logic [3:0] op_r;
  logic [2:0] ep_r;
  logic [15:0] len_r, rlen_r, idx_r, idx_nxt, cnt_r;
  logic [31:0] cmd_word_r;
  logic [7:0] stat_r;
  logic [7:0] evt_r;
  logic [10:0] fn_r;
  logic opt_r, fgood_r, fbad_r, crc_bad_r, rx_none_r;
  logic irq_s1_r, irq_s2_r;
  logic [AW-1:0] ptr_r;
  logic dev_req_r;
  logic dev_we_r;
  logic [7:0] dev_addr_r;
  logic [7:0] dev_wdata_r;
  logic acc_we;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] prep_val;
  logic [7:0] buf_rdata;

  // apb decode
  wire busy = (state_r != uetc_pkg::S_IDLE);
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire apb_rd = apb_acc & ~pwrite;
  wire cmd_wr = apb_wr & (paddr == uetc_pkg::APB_CMD);
  wire start = cmd_wr & ~busy & (first_state(pwdata[uetc_pkg::CMD_OP_LSB +: 4]) != uetc_pkg::S_IDLE);
  wire ptr_wr = apb_wr & ~busy & (paddr == uetc_pkg::APB_PTR);
  wire data_wr = apb_wr & ~busy & (paddr == uetc_pkg::APB_DATA);
  wire data_rd = apb_rd & ~busy & (paddr == uetc_pkg::APB_DATA);
  wire addr_hit = (paddr == uetc_pkg::APB_CMD) | (paddr == uetc_pkg::APB_STAT) | (paddr == uetc_pkg::APB_COUNT)
                | (paddr == uetc_pkg::APB_FRAME) | (paddr == uetc_pkg::APB_EVENTS) | (paddr == uetc_pkg::APB_PTR)
                | (paddr == uetc_pkg::APB_DATA);

  // device access progress
  wire acc_done = dev_req_r & dev_ack;
  wire [2:0] ep_src = busy ? ep_r : pwdata[uetc_pkg::CMD_EP_LSB +: 3];
  wire [7:0] stat_src = (state_r == uetc_pkg::S_STAT_RD) ? dev_rdata
                      : ((state_r == uetc_pkg::S_PREP_WR) ? dev_wdata_r : stat_r);
  wire [7:0] evt_src = (state_r == uetc_pkg::S_EVT_RD) ? dev_rdata : evt_r;
  wire rx_flag_now = (dev_rdata & (uetc_pkg::M_RX_BANK0 | uetc_pkg::M_RX_BANK1)) != 8'h00;
  wire [15:0] rx_len_now = clamp({dev_rdata, cnt_r[7:0]}, RX_CAP);
  wire tx_last = (idx_r == len_r - 16'h0001);
  wire rx_last = (idx_r == rlen_r - 16'h0001);
  wire frame_seen = (dev_rdata & uetc_pkg::M_EV_FRAME) != 8'h00;
  // ready, or stall request for a stall, rides on whatever the earlier write left in place, so dir survives
  wire [7:0] final_val = (op_r == uetc_pkg::OP_STALL) ? (stat_src | uetc_pkg::M_STALL_REQ)
                       : (stat_src | uetc_pkg::M_TX_READY);
  // bank 0 is freed first; in ping-pong the device then swaps to bank 1
  wire [7:0] flag_val = ((stat_r & uetc_pkg::M_RX_BANK0) != 8'h00) ? (stat_r & ~uetc_pkg::M_RX_BANK0)
                      : (stat_r & ~uetc_pkg::M_RX_BANK1);
  wire [7:0] evt_clr_val = evt_src & ~(uetc_pkg::M_EV_FRAME | uetc_pkg::M_EV_BUS_RESET);

  // first status write of the transmit, done, stall, unstall and status commands
  always_comb begin
    prep_val = stat_src;
    case (op_r)
      // only a control in-stage asks for dir; other endpoints are one-way
      uetc_pkg::OP_TX: prep_val = (stat_src & ~uetc_pkg::M_TX_DONE) | (opt_r ? uetc_pkg::M_DIR : 8'h00);
      uetc_pkg::OP_TXDONE: prep_val = stat_src & ~uetc_pkg::M_TX_DONE;
      uetc_pkg::OP_STALL: prep_val = stat_src & ~(uetc_pkg::M_SETUP | uetc_pkg::M_TX_READY | uetc_pkg::M_TX_DONE
                                                  | uetc_pkg::M_RX_BANK0 | uetc_pkg::M_RX_BANK1);
      uetc_pkg::OP_UNSTALL: prep_val = stat_src & ~(uetc_pkg::M_STALL_REQ | uetc_pkg::M_STALL_CRC);
      uetc_pkg::OP_STATUS: prep_val = stat_src & ~(uetc_pkg::M_DIR | uetc_pkg::M_TX_DONE);
      default: prep_val = stat_src;
    endcase
  end

  // sequencer
  always_comb begin
    state_nxt = state_r;
    if (state_r == uetc_pkg::S_IDLE) begin
      if (start) begin
        state_nxt = first_state(pwdata[uetc_pkg::CMD_OP_LSB +: 4]);
      end
    end else if (acc_done) begin
      unique case (state_r)
        uetc_pkg::S_IDLE: state_nxt = uetc_pkg::S_IDLE;
        uetc_pkg::S_SEL: state_nxt = uetc_pkg::S_STAT_RD;
        uetc_pkg::S_STAT_RD: state_nxt = (op_r != uetc_pkg::OP_RX) ? uetc_pkg::S_PREP_WR
                                       : (rx_flag_now ? uetc_pkg::S_CNT_LO : uetc_pkg::S_IDLE);
        uetc_pkg::S_PREP_WR: begin
          if (op_r == uetc_pkg::OP_TX) begin
            state_nxt = (len_r == 16'h0000) ? uetc_pkg::S_FINAL_WR : uetc_pkg::S_DATA_WR;
          end else if (op_r == uetc_pkg::OP_STALL || (op_r == uetc_pkg::OP_STATUS && opt_r)) begin
            state_nxt = uetc_pkg::S_FINAL_WR;
          end else begin
            state_nxt = uetc_pkg::S_IDLE;
          end
        end
        uetc_pkg::S_DATA_WR: state_nxt = tx_last ? uetc_pkg::S_FINAL_WR : uetc_pkg::S_DATA_WR;
        uetc_pkg::S_FINAL_WR: state_nxt = uetc_pkg::S_IDLE;
        uetc_pkg::S_CNT_LO: state_nxt = uetc_pkg::S_CNT_HI;
        uetc_pkg::S_CNT_HI: state_nxt = (rx_len_now == 16'h0000) ? uetc_pkg::S_FLAG_CLR : uetc_pkg::S_DATA_RD;
        uetc_pkg::S_DATA_RD: state_nxt = rx_last ? uetc_pkg::S_FLAG_CLR : uetc_pkg::S_DATA_RD;
        uetc_pkg::S_FLAG_CLR: state_nxt = uetc_pkg::S_IDLE;
        uetc_pkg::S_RST_SET: state_nxt = uetc_pkg::S_RST_CLR;
        uetc_pkg::S_RST_CLR: state_nxt = uetc_pkg::S_IDLE;
        uetc_pkg::S_EVT_RD: state_nxt = frame_seen ? uetc_pkg::S_FN_LO : uetc_pkg::S_EVT_CLR;
        uetc_pkg::S_FN_LO: state_nxt = uetc_pkg::S_FN_HI;
        uetc_pkg::S_FN_HI: state_nxt = uetc_pkg::S_EVT_CLR;
        uetc_pkg::S_EVT_CLR: state_nxt = uetc_pkg::S_IDLE;
      endcase
    end
  end

  // device access issued on entry to each state
  always_comb begin
    acc_we = 1'b0;
    acc_addr = uetc_pkg::D_EP_STATUS;
    acc_wdata = uetc_pkg::RST_BYTE;
    unique case (state_nxt)
      uetc_pkg::S_IDLE, uetc_pkg::S_STAT_RD: acc_addr = uetc_pkg::D_EP_STATUS;
      uetc_pkg::S_SEL: begin
        acc_we = 1'b1;
        acc_addr = uetc_pkg::D_EP_SELECT;
        acc_wdata = {5'h00, ep_src};
      end
      uetc_pkg::S_PREP_WR: begin
        acc_we = 1'b1;
        acc_wdata = prep_val;
      end
      uetc_pkg::S_DATA_WR: begin
        acc_we = 1'b1;
        acc_addr = uetc_pkg::D_FIFO;
      end
      uetc_pkg::S_FINAL_WR: begin
        acc_we = 1'b1;
        acc_wdata = final_val;
      end
      uetc_pkg::S_CNT_LO: acc_addr = uetc_pkg::D_COUNT_LO;
      uetc_pkg::S_CNT_HI: acc_addr = uetc_pkg::D_COUNT_HI;
      uetc_pkg::S_DATA_RD: acc_addr = uetc_pkg::D_FIFO;
      uetc_pkg::S_FLAG_CLR: begin
        acc_we = 1'b1;
        acc_wdata = flag_val;
      end
      uetc_pkg::S_RST_SET: begin
        acc_we = 1'b1;
        acc_addr = uetc_pkg::D_EP_RESET;
        acc_wdata = 8'h01 << ep_src;
      end
      uetc_pkg::S_RST_CLR: begin
        acc_we = 1'b1;
        acc_addr = uetc_pkg::D_EP_RESET;
      end
      uetc_pkg::S_EVT_RD: acc_addr = uetc_pkg::D_EVENTS;
      uetc_pkg::S_FN_LO: acc_addr = uetc_pkg::D_FRAME_LO;
      uetc_pkg::S_FN_HI: acc_addr = uetc_pkg::D_FRAME_HI;
      uetc_pkg::S_EVT_CLR: begin
        acc_we = 1'b1;
        acc_addr = uetc_pkg::D_EVENTS;
        acc_wdata = evt_clr_val;
      end
    endcase
  end

  always_comb begin
    idx_nxt = idx_r;
    if (!busy) begin
      idx_nxt = 16'h0000;
    end else if (acc_done && (state_r == uetc_pkg::S_DATA_WR || state_r == uetc_pkg::S_DATA_RD)) begin
      idx_nxt = idx_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= uetc_pkg::S_IDLE;
      idx_r <= 16'h0000;
      dev_req_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      dev_req_r <= (state_nxt != uetc_pkg::S_IDLE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_we_r <= 1'b0;
      dev_addr_r <= uetc_pkg::RST_BYTE;
      dev_wdata_r <= uetc_pkg::RST_BYTE;
    end else if (start || acc_done) begin
      dev_we_r <= acc_we;
      dev_addr_r <= acc_addr;
      dev_wdata_r <= acc_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= 4'h0;
      ep_r <= 3'h0;
      opt_r <= 1'b0;
      len_r <= 16'h0000;
      cmd_word_r <= uetc_pkg::RST_WORD;
    end else if (start) begin
      op_r <= pwdata[uetc_pkg::CMD_OP_LSB +: 4];
      ep_r <= pwdata[uetc_pkg::CMD_EP_LSB +: 3];
      opt_r <= pwdata[uetc_pkg::CMD_OPT_BIT];
      len_r <= clamp(16'(pwdata[uetc_pkg::CMD_LEN_LSB +: uetc_pkg::CMD_LEN_W]), TX_CAP);
      cmd_word_r <= pwdata;
    end
  end

  // results captured from device reads and from the first status write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= uetc_pkg::RST_BYTE;
      crc_bad_r <= 1'b0;
      rx_none_r <= 1'b0;
    end else if (acc_done && state_r == uetc_pkg::S_STAT_RD) begin
      stat_r <= dev_rdata;
      if (op_r == uetc_pkg::OP_RX) begin
        crc_bad_r <= (dev_rdata & uetc_pkg::M_STALL_CRC) != 8'h00;
        rx_none_r <= ~rx_flag_now;
      end
    end else if (acc_done && state_r == uetc_pkg::S_PREP_WR) begin
      stat_r <= dev_wdata_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      rlen_r <= 16'h0000;
    end else if (acc_done && state_r == uetc_pkg::S_CNT_LO) begin
      cnt_r <= {8'h00, dev_rdata};
    end else if (acc_done && state_r == uetc_pkg::S_CNT_HI) begin
      cnt_r[15:8] <= dev_rdata;
      rlen_r <= rx_len_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= uetc_pkg::RST_BYTE;
      fn_r <= 11'h000;
      fgood_r <= 1'b0;
      fbad_r <= 1'b0;
    end else if (acc_done && state_r == uetc_pkg::S_EVT_RD) begin
      evt_r <= dev_rdata;
    end else if (acc_done && state_r == uetc_pkg::S_FN_LO) begin
      fn_r[7:0] <= dev_rdata;
    end else if (acc_done && state_r == uetc_pkg::S_FN_HI) begin
      fn_r[10:8] <= dev_rdata[2:0];
      fgood_r <= dev_rdata[uetc_pkg::FNH_GOOD_BIT];
      fbad_r <= dev_rdata[uetc_pkg::FNH_BAD_BIT];
    end
  end

  // device interrupt is a pin, so it is synchronised before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end else begin
      irq_s1_r <= dev_irq;
      irq_s2_r <= irq_s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= '0;
    end else if (ptr_wr) begin
      ptr_r <= pwdata[AW-1:0];
    end else if (data_wr || data_rd) begin
      ptr_r <= ptr_r + 1'b1;
    end
  end

  // buffer shared by software (idle) and the sequencer (busy)
  uetc_buf_mem #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH),
    .AW(AW)
  ) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .we(data_wr | (acc_done & (state_r == uetc_pkg::S_DATA_RD))),
    .waddr(busy ? idx_r[AW-1:0] : ptr_r),
    .wdata(busy ? dev_rdata : pwdata[7:0]),
    .raddr(busy ? idx_nxt[AW-1:0] : ptr_r),
    .rdata(buf_rdata)
  );

  // fifo bytes come straight from the buffer's output register
  assign dev_req = dev_req_r;
  assign dev_we = dev_we_r;
  assign dev_addr = dev_addr_r;
  assign dev_wdata = (state_r == uetc_pkg::S_DATA_WR) ? buf_rdata : dev_wdata_r;

  assign pready = 1'b1;
  assign pslverr = apb_acc & ~addr_hit;

  always_comb begin
    prdata = uetc_pkg::RST_WORD;
    case (paddr)
      uetc_pkg::APB_CMD: prdata = cmd_word_r;
      uetc_pkg::APB_STAT: prdata = {16'h0000, stat_r, 4'h0, irq_s2_r, crc_bad_r, rx_none_r, busy};
      uetc_pkg::APB_COUNT: prdata = {16'h0000, cnt_r};
      uetc_pkg::APB_FRAME: prdata = {14'h0000, fbad_r, fgood_r, 5'h00, fn_r};
      uetc_pkg::APB_EVENTS: prdata = {24'h000000, evt_r};
      uetc_pkg::APB_PTR: prdata = 32'(ptr_r);
      uetc_pkg::APB_DATA: prdata = {24'h000000, buf_rdata};
      default: prdata = uetc_pkg::RST_WORD;
    endcase
  end

endmodule : uetc_ctrl

//--- dv/uetc_ctrl_props.sv
// assertion checker bound to the endpoint transaction controller
module uetc_ctrl_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // device port
  input wire logic dev_req,
  input wire logic dev_we,
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_ack,
  input wire logic dev_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic [2:0] ep_w = pwdata[6:4];
  wire logic go = acc && pwrite && paddr == 8'h00 && !dev_req && pwdata[3:0] inside {[4'h1:4'h6]};
  wire logic st_wr = dev_req && dev_we && dev_addr == 8'h01;
  wire logic rst_wr = dev_req && dev_ack && dev_we && dev_addr == 8'h08;
  logic [3:0] op_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) op_r <= 4'h0;
    else if (go) op_r <= pwdata[3:0];
  end
  a_cmd_selects: assert property (go |=> dev_req && dev_we && dev_addr == 8'h00 && dev_wdata == {5'h00, $past(ep_w)})
    else $error("command did not select its endpoint");
  a_req_holds: assert property (dev_req && !dev_ack |=> dev_req && $stable(dev_we) && $stable(dev_addr) && $stable(dev_wdata))
    else $error("device request changed before ack");
  a_req_ends: assert property ($fell(dev_req) |-> $past(dev_ack))
    else $error("device request dropped without ack");
  a_stall_clean: assert property (st_wr && dev_wdata[5] |-> (dev_wdata & 8'h57) == 8'h00)
    else $error("stall requested with flags set");
  a_rst_pulse: assert property (rst_wr && dev_wdata != 8'h00 |=> dev_req && dev_we && dev_addr == 8'h08 && dev_wdata == 8'h00)
    else $error("fifo reset not pulsed");
  a_status_dir: assert property (st_wr && op_r == 4'h6 |-> (dev_wdata & 8'h81) == 8'h00)
    else $error("status stage kept direction or done");
  a_txdone_clear: assert property (st_wr && op_r == 4'h3 |-> !dev_wdata[0])
    else $error("done flag not cleared");
  a_rx_one_bank: assert property (st_wr && op_r == 4'h2 |-> (dev_wdata & 8'h42) != 8'h42)
    else $error("receive did not free a bank");
  a_irq_shown: assert property (acc && paddr == 8'h04 |-> prdata[3] == $past(dev_irq, 2))
    else $error("interrupt pin not shown in status");
endmodule : uetc_ctrl_chk

bind uetc_ctrl uetc_ctrl_chk u_uetc_ctrl_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .dev_req, .dev_we, .dev_addr, .dev_wdata, .dev_ack, .dev_irq);

//--- dv/uetc_dev_model.sv
// behavioural endpoint logic behind the device register port
module uetc_dev_model (
  // clock
  input wire logic pclk,
  // register port
  input wire logic dev_req,
  input wire logic dev_we,
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  output logic [7:0] dev_rdata,
  output logic dev_ack,
  output logic dev_irq,
  // acks after two wait cycles when set
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  // flags only the device sets; firmware may clear them, writing 1 leaves them alone
  localparam logic [7:0] HW = 8'h4F;
  logic [7:0] sel, ev, fnl, fnh, rst_seen, rd;
  logic [7:0] st [8];
  logic [15:0] cnt [8];
  logic [7:0] mem [8][64];
  logic [5:0] rp [8];
  logic [5:0] wp [8];
  logic [1:0] wt = 2'd0;
  logic bank5;
  int sent;
  wire logic [2:0] e = sel[2:0];
  assign dev_ack = dev_req && (!slow || wt == 2'd2);
  // no stale data outside an ack
  assign dev_rdata = dev_ack ? rd : ~rd;
  always_comb begin
    dev_irq = ev != 8'h00;
    for (int i = 0; i < 8; i++) dev_irq = dev_irq || (st[i] & HW) != 8'h00;
    case (dev_addr)
      8'h01: rd = st[e];
      8'h02: rd = mem[e][rp[e]];
      8'h03: rd = cnt[e][7:0];
      8'h04: rd = cnt[e][15:8];
      8'h05: rd = ev;
      8'h06: rd = fnl;
      8'h07: rd = fnh;
      default: rd = sel;
    endcase
  end
  always @(posedge pclk) begin
    wt <= (dev_req && !dev_ack) ? wt + 2'd1 : 2'd0;
    if (dev_ack && dev_we) begin
      case (dev_addr)
        8'h00: sel <= dev_wdata;
        8'h01: st[e] <= (st[e] & dev_wdata & HW) | (dev_wdata & ~HW);
        8'h02: begin
          mem[e][wp[e]] <= dev_wdata;
          wp[e] <= wp[e] + 6'd1;
        end
        8'h05: ev <= ev & dev_wdata;
        8'h08: rst_seen <= rst_seen | dev_wdata;
        default: ;
      endcase
    end
    if (dev_ack && !dev_we && dev_addr == 8'h02) rp[e] <= rp[e] + 6'd1;
  end
  task automatic wipe();
    {sel, ev, fnl, fnh, rst_seen} = 40'h0;
    bank5 = 1'b0;
    for (int i = 0; i < 8; i++) begin
      st[i] = 8'h00;
      cnt[i] = 16'h0;
      wp[i] = 6'h0;
    end
  endtask : wipe
  task automatic host_out(input int ep, input int n, input bit bad);
    logic [7:0] f;
    f = (ep == 5 && bank5) ? 8'h40 : 8'h02;
    if ((st[ep] & f) != 8'h00) return;
    for (int i = 0; i < n && i < 64; i++) mem[ep][i] = 8'hA0 + 8'(i);
    cnt[ep] = 16'(n);
    st[ep] = (st[ep] & 8'hF7) | f | (bad ? 8'h08 : 8'h00);
    rp[ep] = 6'h0;
    bank5 = bank5 ^ (ep == 5);
  endtask : host_out
  task automatic host_in(input int ep);
    sent = -1;
    if (st[ep][5]) begin
      st[ep] = st[ep] | 8'h08;
    end else if (st[ep][4]) begin
      sent = wp[ep];
      wp[ep] = 6'h0;
      st[ep] = (st[ep] & 8'hEF) | 8'h01;
    end
  endtask : host_in
  task automatic host_sof(input logic [10:0] fr, input bit good);
    fnl = fr[7:0];
    fnh = {3'h0, !good, good, fr[10:8]};
    ev = ev | 8'h08;
  endtask : host_sof
  task automatic usb_reset();
    wipe();
    ev = 8'h10;
  endtask : usb_reset
  task automatic host_setup(input int ep);
    st[ep] = 8'h04;
  endtask : host_setup
endmodule : uetc_dev_model

//--- dv/tb_usb_endpoint_transaction_control.sv
// bench: apb orders to the controller, behavioural device on its register port
module tb_usb_endpoint_transaction_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic dev_req, dev_we, dev_ack, dev_irq, slow;
  logic [7:0] paddr, dev_addr, dev_wdata, dev_rdata;
  logic [31:0] pwdata, prdata, rd;
  int fail_count, total_checks;
  uetc_ctrl u_uetc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .dev_req, .dev_we, .dev_addr, .dev_wdata, .dev_rdata, .dev_ack, .dev_irq);
  uetc_dev_model dm (.pclk, .dev_req, .dev_we, .dev_addr, .dev_wdata, .dev_rdata, .dev_ack, .dev_irq, .slow);
  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer, closed at the edge that samples pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // issue a command and poll the busy bit; rd ends holding the idle status word
  task automatic cmd(input logic [3:0] op, input logic [2:0] ep, input logic opt, input logic [9:0] len);
    int n;
    apb(1'b1, 8'h00, {6'h00, len, 7'h00, opt, 1'b0, ep, op});
    for (n = 0; n < 100; n++) begin
      apb(1'b0, 8'h04, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 100) begin
      fail_count++;
      end_sim();
    end
  endtask : cmd
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    slow = 1'b1;
    fail_count = 0;
    total_checks = 0;
    dm.wipe();
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk("stat", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("pslverr", 32'h1, err);
    // control in data stage, device answering slowly
    apb(1'b1, 8'h14, 32'h0);
    for (int i = 0; i < 3; i++) apb(1'b1, 8'h18, 32'h30 + i);
    cmd(4'h1, 3'd0, 1'b1, 10'd3);
    chk("ep0 stat", 32'h90, dm.st[0]);
    chk("fifo byte", 32'h32, dm.mem[0][2]);
    dm.host_in(0);
    chk("in bytes", 32'h3, dm.sent);
    cmd(4'h3, 3'd0, 1'b0, 10'd0);
    chk("done clear", 32'h80, dm.st[0]);
    dm.host_in(0);
    chk("nothing sent", 32'hFFFF_FFFF, dm.sent);
    cmd(4'h6, 3'd0, 1'b1, 10'd0);
    chk("status stage", 32'h10, dm.st[0]);
    dm.host_in(0);
    chk("zlp in", 32'h0, dm.sent);
    slow <= 1'b0;
    // iso out: overflowing bad packet, then one that must be dropped
    dm.host_out(3, 70, 1'b1);
    dm.host_out(3, 2, 1'b0);
    cmd(4'h2, 3'd3, 1'b0, 10'd0);
    chk("crc bad", 32'h4, rd & 32'h6);
    apb(1'b0, 8'h08, 32'h0);
    chk("count", 32'd70, rd);
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk("rx byte", 32'hA1, rd & 32'hFF);
    chk("bank free", 32'h0, dm.st[3] & 8'h02);
    cmd(4'h2, 3'd3, 1'b0, 10'd0);
    chk("no packet", 32'h2, rd & 32'h2);
    dm.host_out(3, 0, 1'b0);
    cmd(4'h2, 3'd3, 1'b0, 10'd0);
    chk("zlp crc", 32'h0, rd & 32'h6);
    apb(1'b0, 8'h08, 32'h0);
    chk("zlp count", 32'h0, rd);
    // ping-pong banks
    dm.host_out(5, 4, 1'b0);
    dm.host_out(5, 6, 1'b0);
    chk("two banks", 32'h42, dm.st[5]);
    cmd(4'h2, 3'd5, 1'b0, 10'd0);
    chk("bank0 free", 32'h40, dm.st[5]);
    cmd(4'h2, 3'd5, 1'b0, 10'd0);
    chk("bank1 free", 32'h0, dm.st[5]);
    // stall with setup and receive flags pending, then release
    dm.host_setup(1);
    dm.host_out(1, 1, 1'b0);
    cmd(4'h4, 3'd1, 1'b0, 10'd0);
    chk("stall", 32'h20, dm.st[1]);
    dm.host_in(1);
    cmd(4'h5, 3'd1, 1'b0, 10'd0);
    chk("unstall", 32'h0, dm.st[1]);
    cmd(4'h7, 3'd2, 1'b0, 10'd0);
    chk("ep reset", 32'h4, dm.rst_seen);
    // frame start and bus reset events
    dm.host_sof(11'h5A3, 1'b1);
    cmd(4'h8, 3'd0, 1'b0, 10'd0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("frame", 32'h0001_05A3, rd);
    chk("ev clear", 32'h0, dm.ev);
    dm.usb_reset();
    dm.host_sof(11'h7FF, 1'b0);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk("irq set", 32'h8, rd & 32'h8);
    cmd(4'h8, 3'd0, 1'b0, 10'd0);
    apb(1'b0, 8'h10, 32'h0);
    chk("events", 32'h18, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("bad frame", 32'h0002_07FF, rd);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    chk("irq idle", 32'h0, rd & 32'h8);
    end_sim();
  end
endmodule : tb_usb_endpoint_transaction_control
